// ---- verilog/ecr_ext_ctrl.sv ----
// Extended control register with strap address latch, line encoder and coder hookup
`timescale 1ns/100ps
`default_nettype none
`include "ecr_params.svh"

// Function
// - Bit 15 unlocks protected bits for next write
// - Unlock bit self-clears after the following write
// - Reserved bits 14:11, 4, 1 read zero
// - Address bits latched from strap pins at reset
// - Software reset keeps latched address
// - Bit 5 forces receiver loss of lock
// - Bit 3 picks NRZ or NRZI, resets one
// - Bit 2 clear gives standard 4B/5B coding
// - Test with error: low nibbles pass straight
// - Test with error: high nibbles use table
// - Bit 0 bypasses scrambler and descrambler
module ecr_ext_ctrl #(
	parameter int STRAP_W = `ECR_STRAP_W
) (
	input  wire logic               clock,
	input  wire logic               rstn,
	input  wire logic               soft_reset,
	input  wire logic [STRAP_W-1:0] addr_strap_pins,
	input  wire logic               mgmt_wr,
	input  wire logic               mgmt_rd,
	input  wire logic [4:0]         mgmt_reg_addr,
	input  wire logic [15:0]        mgmt_wdata,
	output logic [15:0]             mgmt_rdata,
	output logic                    mgmt_rd_valid,
	output logic                    override_write_enable,
	output logic [STRAP_W-1:0]      phy_address,
	output logic                    scrambler_lock_test,
	output logic                    scrambler_bypass,
	input  wire logic [3:0]         tx_nibble,
	input  wire logic               tx_nibble_valid,
	input  wire logic               tx_er,
	output logic [4:0]              tx_symbol,
	output logic                    tx_symbol_valid,
	input  wire logic               tx_serial_bit,
	input  wire logic               tx_serial_valid,
	output logic                    tx_line_bit
);
	import ecr_pkg::*;

	// The address field is fixed at five bits in the register layout
	if (STRAP_W != `ECR_STRAP_W) begin : g_bad_width
		$error("STRAP_W must match the five-bit address field");
	end

	ecr_state_t q;
	ecr_state_t next_q;
	ecr_coder_if cif ();

	// Register image as software sees it; reserved bits never carry state
	function automatic logic [15:0] reg_image(input ecr_state_t s);
		logic [15:0] v;
		v = 16'h0000;
		v[`ECR_BIT_UNLOCK] = s.unlock;
		v[`ECR_ADDR_MSB:`ECR_ADDR_LSB] = s.phy_addr;
		v[`ECR_BIT_CTEST] = s.cipher_test;
		v[`ECR_BIT_NRZI] = s.nrzi_sel;
		v[`ECR_BIT_INVAL] = s.invalid_test;
		v[`ECR_BIT_CDIS] = s.cipher_dis;
		reg_image = v;
	endfunction

	// Restore the writable controls to their defaults, leaving the address alone
	function automatic ecr_state_t ctrl_defaults(input ecr_state_t s);
		ecr_state_t r;
		r = s;
		r.unlock = `ECR_RST_UNLOCK;
		r.cipher_test = `ECR_RST_CTEST;
		r.nrzi_sel = `ECR_RST_NRZI;
		r.invalid_test = `ECR_RST_INVAL;
		r.cipher_dis = `ECR_RST_CDIS;
		ctrl_defaults = r;
	endfunction

	// Next state: strap sync, register writes, self-clear, reads, line coding
	always_comb begin
		logic ecr_hit;
		ecr_hit = (mgmt_reg_addr == `ECR_REG_ADDR);
		next_q = q;
		// Strap pins are asynchronous; only the second stage feeds the latch
		next_q.sync1 = addr_strap_pins;
		next_q.sync2 = q.sync1;
		// Read data is the pre-write image when a read and write coincide
		next_q.rvalid = mgmt_rd && ecr_hit;
		if (mgmt_rd && ecr_hit)
			next_q.rdata = reg_image(q);
		if (mgmt_wr) begin
			// Any write consumes the unlock; a write here may re-arm it
			next_q.unlock = 1'b0;
			if (ecr_hit) begin
				next_q.unlock = mgmt_wdata[`ECR_BIT_UNLOCK];
				next_q.cipher_test = mgmt_wdata[`ECR_BIT_CTEST];
				next_q.nrzi_sel = mgmt_wdata[`ECR_BIT_NRZI];
				next_q.invalid_test = mgmt_wdata[`ECR_BIT_INVAL];
				next_q.cipher_dis = mgmt_wdata[`ECR_BIT_CDIS];
			end
		end
		// NRZI toggles the line on a one, NRZ copies the bit
		if (tx_serial_valid)
			next_q.line_bit = q.nrzi_sel ? (q.line_bit ^ tx_serial_bit) : tx_serial_bit;
		// Software reset beats a same-cycle write and spares the address
		if (soft_reset)
			next_q = ctrl_defaults(next_q);
		// Hardware reset keeps reloading the address from the synchronised pins
		if (!rstn) begin
			next_q = ctrl_defaults(q);
			next_q.sync1 = addr_strap_pins;
			next_q.sync2 = q.sync1;
			next_q.phy_addr = q.sync2;
			next_q.rdata = 16'h0000;
			next_q.rvalid = 1'b0;
			next_q.line_bit = 1'b0;
		end
	end

	// Single register stage for the whole block
	always_ff @(posedge clock) begin
		q <= next_q;
	end

	// Coder sees the test enable straight from the register
	assign cif.nibble       = tx_nibble;
	assign cif.nib_valid    = tx_nibble_valid;
	assign cif.txer         = tx_er;
	assign cif.invalid_test = q.invalid_test;

	ecr_tx_coder u_coder (
		.clock (clock),
		.rstn  (rstn),
		.cif   (cif)
	);

	// Outputs all come from flops
	assign mgmt_rdata            = q.rdata;
	assign mgmt_rd_valid         = q.rvalid;
	assign override_write_enable = q.unlock;
	assign phy_address           = q.phy_addr;
	assign scrambler_lock_test   = q.cipher_test;
	assign scrambler_bypass      = q.cipher_dis;
	assign tx_symbol             = cif.symbol;
	assign tx_symbol_valid       = cif.sym_valid;
	assign tx_line_bit           = q.line_bit;

	property p_unlock_set;
		@(posedge clock) disable iff (!rstn)
		mgmt_wr && mgmt_reg_addr == `ECR_REG_ADDR && mgmt_wdata[`ECR_BIT_UNLOCK] && !soft_reset
			|=> override_write_enable;
	endproperty
	a_unlock_set: assert property (p_unlock_set) else $error("unlock not set");

	property p_unlock_clear;
		@(posedge clock) disable iff (!rstn)
		override_write_enable && mgmt_wr && mgmt_reg_addr != `ECR_REG_ADDR
			|=> !override_write_enable;
	endproperty
	a_unlock_clear: assert property (p_unlock_clear) else $error("unlock not cleared");

	property p_unlock_holds;
		@(posedge clock) disable iff (!rstn)
		override_write_enable && !mgmt_wr && !soft_reset |=> override_write_enable;
	endproperty
	a_unlock_holds: assert property (p_unlock_holds) else $error("unlock lost early");

	property p_rsv_zero;
		@(posedge clock) disable iff (!rstn)
		mgmt_rd_valid |-> mgmt_rdata[`ECR_RSV_HI_MSB:`ECR_RSV_HI_LSB] == 4'h0
			&& !mgmt_rdata[`ECR_BIT_RSV4] && !mgmt_rdata[`ECR_BIT_RSV1];
	endproperty
	a_rsv_zero: assert property (p_rsv_zero) else $error("reserved bit read nonzero");

	property p_addr_readback;
		@(posedge clock) disable iff (!rstn)
		mgmt_rd && mgmt_reg_addr == `ECR_REG_ADDR
			|=> mgmt_rd_valid && mgmt_rdata[`ECR_ADDR_MSB:`ECR_ADDR_LSB] == phy_address;
	endproperty
	a_addr_readback: assert property (p_addr_readback) else $error("address readback wrong");

	property p_addr_swreset;
		@(posedge clock) disable iff (!rstn)
		soft_reset |=> $stable(phy_address) && phy_address == $past(phy_address);
	endproperty
	a_addr_swreset: assert property (p_addr_swreset) else $error("soft reset moved address");

	property p_reset_value;
		@(posedge clock)
		$rose(rstn) |-> scrambler_bypass == 1'b0 && scrambler_lock_test == 1'b0
			&& !override_write_enable && q.nrzi_sel && !q.invalid_test;
	endproperty
	a_reset_value: assert property (p_reset_value) else $error("reset value wrong");

	property p_lock_test_write;
		@(posedge clock) disable iff (!rstn)
		mgmt_wr && mgmt_reg_addr == `ECR_REG_ADDR && !soft_reset
			|=> scrambler_lock_test == $past(mgmt_wdata[`ECR_BIT_CTEST]);
	endproperty
	a_lock_test_write: assert property (p_lock_test_write) else $error("lock test bad");

	property p_bypass_write;
		@(posedge clock) disable iff (!rstn)
		mgmt_wr && mgmt_reg_addr == `ECR_REG_ADDR && !soft_reset
			|=> scrambler_bypass == $past(mgmt_wdata[`ECR_BIT_CDIS]);
	endproperty
	a_bypass_write: assert property (p_bypass_write) else $error("bypass bit bad");

	property p_line_code;
		@(posedge clock) disable iff (!rstn)
		tx_serial_valid && !soft_reset
			|=> tx_line_bit == ($past(q.nrzi_sel) ? ($past(tx_serial_bit) ^ $past(tx_line_bit))
				: $past(tx_serial_bit));
	endproperty
	a_line_code: assert property (p_line_code) else $error("line coding wrong");

	// Unlock rises only through a write of this register
	property p_unlock_idle;
		@(posedge clock) disable iff (!rstn)
		!override_write_enable && !(mgmt_wr && mgmt_reg_addr == `ECR_REG_ADDR)
			|=> !override_write_enable;
	endproperty
	a_unlock_idle: assert property (p_unlock_idle) else $error("unlock set alone");

	// Read image carries the control bits as they stood at the strobe edge
	property p_image_read;
		@(posedge clock) disable iff (!rstn)
		mgmt_rd && mgmt_reg_addr == `ECR_REG_ADDR
			|=> mgmt_rdata[`ECR_BIT_UNLOCK] == $past(override_write_enable)
			&& mgmt_rdata[`ECR_BIT_CTEST] == $past(scrambler_lock_test)
			&& mgmt_rdata[`ECR_BIT_NRZI] == $past(q.nrzi_sel)
			&& mgmt_rdata[`ECR_BIT_INVAL] == $past(q.invalid_test)
			&& mgmt_rdata[`ECR_BIT_CDIS] == $past(scrambler_bypass);
	endproperty
	a_image_read: assert property (p_image_read) else $error("image wrong");

	// Encoding select and test enable follow the written bits
	property p_nrzi_write;
		@(posedge clock) disable iff (!rstn)
		mgmt_wr && mgmt_reg_addr == `ECR_REG_ADDR && !soft_reset
			|=> q.nrzi_sel == $past(mgmt_wdata[`ECR_BIT_NRZI]);
	endproperty
	a_nrzi_write: assert property (p_nrzi_write) else $error("encoding bit bad");

	property p_inval_write;
		@(posedge clock) disable iff (!rstn)
		mgmt_wr && mgmt_reg_addr == `ECR_REG_ADDR && !soft_reset
			|=> q.invalid_test == $past(mgmt_wdata[`ECR_BIT_INVAL]);
	endproperty
	a_inval_write: assert property (p_inval_write) else $error("test enable bad");

	// Controls move only on a write here or a software reset
	property p_ctrl_hold;
		@(posedge clock) disable iff (!rstn)
		!(mgmt_wr && mgmt_reg_addr == `ECR_REG_ADDR) && !soft_reset
			|=> $stable(scrambler_lock_test) && $stable(scrambler_bypass)
			&& $stable(q.nrzi_sel) && $stable(q.invalid_test);
	endproperty
	a_ctrl_hold: assert property (p_ctrl_hold) else $error("control moved alone");

	// Software reset restores every writable control, unlock included
	property p_soft_defaults;
		@(posedge clock) disable iff (!rstn)
		soft_reset |=> override_write_enable == `ECR_RST_UNLOCK
			&& scrambler_lock_test == `ECR_RST_CTEST && scrambler_bypass == `ECR_RST_CDIS
			&& q.nrzi_sel == `ECR_RST_NRZI && q.invalid_test == `ECR_RST_INVAL;
	endproperty
	a_soft_defaults: assert property (p_soft_defaults) else $error("soft reset value");

	// Address changes only under hardware reset, never while running
	property p_addr_fixed;
		@(posedge clock) disable iff (!rstn)
		1'b1 |=> $stable(phy_address);
	endproperty
	a_addr_fixed: assert property (p_addr_fixed) else $error("address moved");

	// Reads elsewhere leave valid low and the last data held
	property p_rd_quiet;
		@(posedge clock) disable iff (!rstn)
		!(mgmt_rd && mgmt_reg_addr == `ECR_REG_ADDR)
			|=> !mgmt_rd_valid && $stable(mgmt_rdata);
	endproperty
	a_rd_quiet: assert property (p_rd_quiet) else $error("spurious read data");

	// Line holds between bits; plain NRZ copies the bit
	property p_line_hold;
		@(posedge clock) disable iff (!rstn)
		!tx_serial_valid |=> $stable(tx_line_bit);
	endproperty
	a_line_hold: assert property (p_line_hold) else $error("line moved idle");

	property p_nrz_copy;
		@(posedge clock) disable iff (!rstn)
		tx_serial_valid && !q.nrzi_sel |=> tx_line_bit == $past(tx_serial_bit);
	endproperty
	a_nrz_copy: assert property (p_nrz_copy) else $error("NRZ bit wrong");

	c_unlock_then_write: cover property (@(posedge clock) disable iff (!rstn)
		override_write_enable ##0 mgmt_wr && mgmt_reg_addr != `ECR_REG_ADDR
		##1 !override_write_enable);
	c_soft_reset: cover property (@(posedge clock) disable iff (!rstn)
		soft_reset && q.invalid_test ##1 !q.invalid_test);
	c_nrz_mode: cover property (@(posedge clock) disable iff (!rstn)
		!q.nrzi_sel && tx_serial_valid);
	c_unlock_rearm: cover property (@(posedge clock) disable iff (!rstn)
		override_write_enable ##0 mgmt_wr && mgmt_reg_addr == `ECR_REG_ADDR
		##1 override_write_enable);
endmodule // ecr_ext_ctrl

`default_nettype wire

// ---- verilog/ecr_params.svh ----
// Register location, field positions and reset values of the extended control register
`ifndef ECR_PARAMS_SVH
`define ECR_PARAMS_SVH

`define ECR_REG_ADDR     5'h10
`define ECR_BIT_UNLOCK   15
`define ECR_RSV_HI_MSB   14
`define ECR_RSV_HI_LSB   11
`define ECR_ADDR_MSB     10
`define ECR_ADDR_LSB     6
`define ECR_BIT_CTEST    5
`define ECR_BIT_RSV4     4
`define ECR_BIT_NRZI     3
`define ECR_BIT_INVAL    2
`define ECR_BIT_RSV1     1
`define ECR_BIT_CDIS     0
`define ECR_RST_UNLOCK   1'b0
`define ECR_RST_CTEST    1'b0
`define ECR_RST_NRZI     1'b1
`define ECR_RST_INVAL    1'b0
`define ECR_RST_CDIS     1'b0
`define ECR_STRAP_W      5

`endif

// ---- verilog/ecr_pkg.sv ----
// Types shared by the extended control register and its transmit coder
package ecr_pkg;

	// Register and line state of the control block
	typedef struct packed {
		logic        unlock;
		logic [4:0]  phy_addr;
		logic        cipher_test;
		logic        nrzi_sel;
		logic        invalid_test;
		logic        cipher_dis;
		logic [4:0]  sync1;
		logic [4:0]  sync2;
		logic [15:0] rdata;
		logic        rvalid;
		logic        line_bit;
	} ecr_state_t;

	// State of the nibble-to-symbol coder
	typedef struct packed {
		logic [4:0] symbol;
		logic       valid;
	} ecr_coder_state_t;

endpackage

// ---- verilog/ecr_coder_if.sv ----
// Nibble and symbol signals between the control block and the transmit coder
`timescale 1ns/100ps
`default_nettype none

interface ecr_coder_if;
	logic [3:0] nibble;
	logic       nib_valid;
	logic       txer;
	logic       invalid_test;
	logic [4:0] symbol;
	logic       sym_valid;

	modport ctrl  (output nibble, output nib_valid, output txer, output invalid_test,
		input symbol, input sym_valid);
	modport coder (input nibble, input nib_valid, input txer, input invalid_test,
		output symbol, output sym_valid);
endinterface

`default_nettype wire

// ---- verilog/ecr_tx_coder.sv ----
// Nibble to 5-bit symbol coder with the invalid-code test translation
`timescale 1ns/100ps
`default_nettype none
`include "ecr_params.svh"

module ecr_tx_coder (
	input  wire logic    clock,
	input  wire logic    rstn,
	ecr_coder_if.coder   cif
);
	import ecr_pkg::*;

	ecr_coder_state_t q;
	ecr_coder_state_t next_q;

	// Standard 4B/5B data code
	function automatic logic [4:0] std_code(input logic [3:0] n);
		case (n)
			4'h0: std_code = 5'h1e;
			4'h1: std_code = 5'h09;
			4'h2: std_code = 5'h14;
			4'h3: std_code = 5'h15;
			4'h4: std_code = 5'h0a;
			4'h5: std_code = 5'h0b;
			4'h6: std_code = 5'h0e;
			4'h7: std_code = 5'h0f;
			4'h8: std_code = 5'h12;
			4'h9: std_code = 5'h13;
			4'ha: std_code = 5'h16;
			4'hb: std_code = 5'h17;
			4'hc: std_code = 5'h1a;
			4'hd: std_code = 5'h1b;
			4'he: std_code = 5'h1c;
			default: std_code = 5'h1d;
		endcase
	endfunction

	// Test translation: low half passes straight, high half yields control and bad codes
	function automatic logic [4:0] test_code(input logic [3:0] n);
		case (n)
			4'h8: test_code = 5'h00;
			4'h9: test_code = 5'h0d;
			4'ha: test_code = 5'h0c;
			4'hb: test_code = 5'h11;
			4'hc: test_code = 5'h10;
			4'hd: test_code = 5'h19;
			4'he: test_code = 5'h18;
			4'hf: test_code = 5'h1f;
			default: test_code = {1'b0, n};
		endcase
	endfunction

	// Choose the table per nibble; test table only with the error strobe high
	always_comb begin
		next_q = q;
		next_q.valid = cif.nib_valid;
		if (cif.nib_valid) begin
			if (cif.invalid_test && cif.txer)
				next_q.symbol = test_code(cif.nibble);
			else
				next_q.symbol = std_code(cif.nibble);
		end
		if (!rstn)
			next_q = '0;
	end

	always_ff @(posedge clock) begin
		q <= next_q;
	end

	assign cif.symbol    = q.symbol;
	assign cif.sym_valid = q.valid;

	property p_std_zero;
		@(posedge clock) disable iff (!rstn)
		cif.nib_valid && !(cif.invalid_test && cif.txer) && cif.nibble == 4'h0
			|=> cif.sym_valid && cif.symbol == 5'h1e;
	endproperty
	a_std_zero: assert property (p_std_zero) else $error("standard code for 0 wrong");

	property p_low_pass;
		@(posedge clock) disable iff (!rstn)
		cif.nib_valid && cif.invalid_test && cif.txer && !cif.nibble[3]
			|=> cif.symbol == {1'b0, $past(cif.nibble)};
	endproperty
	a_low_pass: assert property (p_low_pass) else $error("low test nibble not passed");

	property p_high_nine;
		@(posedge clock) disable iff (!rstn)
		cif.nib_valid && cif.invalid_test && cif.txer && cif.nibble == 4'h9
			|=> cif.symbol == 5'h0d;
	endproperty
	a_high_nine: assert property (p_high_nine) else $error("test nibble 9 wrong");

	c_test_symbol: cover property (@(posedge clock) disable iff (!rstn)
		cif.nib_valid && cif.invalid_test && cif.txer ##1 cif.sym_valid);
endmodule // ecr_tx_coder

`default_nettype wire

// ---- test/ecr_mgr_model.sv ----
// Station management controller model driving the decoded register access port
`timescale 1ns/100ps
`default_nettype none

module ecr_mgr_model (
	input  wire logic        clock,
	input  wire logic [15:0] mgmt_rdata,
	input  wire logic        mgmt_rd_valid,
	output logic             mgmt_wr,
	output logic             mgmt_rd,
	output logic [4:0]       mgmt_reg_addr,
	output logic [15:0]      mgmt_wdata
);
	localparam logic [15:0] RSV_MASK = 16'h7812;

	// Idle bus shows the inverse of the last value so stale data never looks valid
	initial begin
		mgmt_wr = 1'b0;
		mgmt_rd = 1'b0;
		mgmt_reg_addr = 5'h0f;
		mgmt_wdata = 16'h0000;
	end

	// One write, reserved bits forced to their defaults
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge clock) #1;
		mgmt_wr = 1'b1;
		mgmt_reg_addr = a;
		mgmt_wdata = d & ~RSV_MASK;
		@(posedge clock) #1;
		mgmt_wr = 1'b0;
		mgmt_reg_addr = ~a;
		mgmt_wdata = ~mgmt_wdata;
	endtask

	// Unlock then write the protected target; repeated for every target
	task automatic prot_wr(input logic [4:0] a, input logic [15:0] d, input logic [15:0] ctl);
		wr(5'h10, ctl | 16'h8000);
		wr(a, d);
	endtask

	// One read; valid is taken in the cycle after the strobe edge
	task automatic rd(input logic [4:0] a, output logic [15:0] d, output logic v);
		@(posedge clock) #1;
		mgmt_rd = 1'b1;
		mgmt_reg_addr = a;
		@(posedge clock) #1;
		mgmt_rd = 1'b0;
		mgmt_reg_addr = ~a;
		v = mgmt_rd_valid;
		d = mgmt_rdata;
	endtask
endmodule // ecr_mgr_model

`default_nettype wire

// ---- test/test_phy_extended_control_register.sv ----
// Self-checking bench for the extended control register block
`timescale 1ns/100ps
`default_nettype none

`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin error_cnt++; $display("[ERR] %0t got %h exp %h", $time, got, exp); end end

module test_phy_extended_control_register;
	logic        clock;
	logic        rstn;
	logic        soft_reset;
	logic [4:0]  strap;
	logic        mgmt_wr;
	logic        mgmt_rd;
	logic [4:0]  mgmt_reg_addr;
	logic [15:0] mgmt_wdata;
	logic [15:0] mgmt_rdata;
	logic        mgmt_rd_valid;
	logic        owe;
	logic [4:0]  phy_address;
	logic        lock_test;
	logic        bypass;
	logic [3:0]  tx_nibble;
	logic        tx_nibble_valid;
	logic        tx_er;
	logic [4:0]  tx_symbol;
	logic        tx_symbol_valid;
	logic        ser_bit;
	logic        ser_valid;
	logic        tx_line_bit;
	int          error_cnt;
	int          cmp_count;
	logic [15:0] rd_d;
	logic        rd_v;
	logic        line_exp;
	localparam logic [4:0] STD [16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
		5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
	localparam logic [4:0] TST [16] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07,
		5'h00, 5'h0d, 5'h0c, 5'h11, 5'h10, 5'h19, 5'h18, 5'h1f};

	ecr_ext_ctrl #(.STRAP_W(5)) dut_u (.clock(clock), .rstn(rstn), .soft_reset(soft_reset),
		.addr_strap_pins(strap), .mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd),
		.mgmt_reg_addr(mgmt_reg_addr), .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata),
		.mgmt_rd_valid(mgmt_rd_valid), .override_write_enable(owe), .phy_address(phy_address),
		.scrambler_lock_test(lock_test), .scrambler_bypass(bypass), .tx_nibble(tx_nibble),
		.tx_nibble_valid(tx_nibble_valid), .tx_er(tx_er), .tx_symbol(tx_symbol),
		.tx_symbol_valid(tx_symbol_valid), .tx_serial_bit(ser_bit),
		.tx_serial_valid(ser_valid), .tx_line_bit(tx_line_bit));

	ecr_mgr_model mgr_u (.clock(clock), .mgmt_rdata(mgmt_rdata), .mgmt_rd_valid(mgmt_rd_valid),
		.mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd), .mgmt_reg_addr(mgmt_reg_addr),
		.mgmt_wdata(mgmt_wdata));

	// 100 MHz clock
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	// Closing verdict, shared by the main sequence and the watchdog
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// Read the register and compare the whole image
	task automatic rchk(input logic [15:0] exp);
		mgr_u.rd(5'h10, rd_d, rd_v);
		`CHK(rd_v, 1'b1)
		`CHK(rd_d, exp)
	endtask

	// One nibble through the coder, symbol seen one cycle later
	task automatic nib(input logic [3:0] n, input logic er, input logic [4:0] exp);
		@(posedge clock) #1;
		tx_nibble = n;
		tx_er = er;
		tx_nibble_valid = 1'b1;
		@(posedge clock) #1;
		tx_nibble_valid = 1'b0;
		`CHK(tx_symbol_valid, 1'b1)
		`CHK(tx_symbol, exp)
	endtask

	// One serial bit through the line encoder
	task automatic sbit(input logic b, input logic exp);
		@(posedge clock) #1;
		ser_bit = b;
		ser_valid = 1'b1;
		@(posedge clock) #1;
		ser_valid = 1'b0;
		`CHK(tx_line_bit, exp)
	endtask

	// Hardware reset held three cycles with the strap already stable
	task automatic hw_reset();
		rstn = 1'b0;
		repeat (3) @(posedge clock);
		#1 rstn = 1'b1;
	endtask

	// Watchdog well beyond the roughly 150 cycles the tests need
	initial begin
		#50000;
		error_cnt++;
		stop_test();
	end

	initial begin
		error_cnt = 0;
		cmp_count = 0;
		soft_reset = 1'b0;
		strap = 5'h15;
		tx_nibble = 4'h0;
		tx_nibble_valid = 1'b0;
		tx_er = 1'b0;
		ser_bit = 1'b0;
		ser_valid = 1'b0;
		hw_reset();
		rchk(16'h0548);
		`CHK(phy_address, 5'h15)
		mgr_u.rd(5'h11, rd_d, rd_v);
		`CHK(rd_v, 1'b0)
		$display("test reset image done");
		// Address bits are read-only, control bits read back
		mgr_u.wr(5'h10, 16'h07ed);
		rchk(16'h056d);
		`CHK(lock_test, 1'b1)
		`CHK(bypass, 1'b1)
		$display("test control bits done");
		// Unlock lasts exactly one following write, to any address
		mgr_u.wr(5'h10, 16'h8008);
		`CHK(owe, 1'b1)
		mgr_u.wr(5'h00, 16'h1234);
		`CHK(owe, 1'b0)
		mgr_u.prot_wr(5'h10, 16'h8008, 16'h0008);
		`CHK(owe, 1'b1)
		mgr_u.prot_wr(5'h04, 16'h0001, 16'h0008);
		`CHK(owe, 1'b0)
		$display("test unlock done");
		// Software reset restores controls and unlock but keeps the address,
		// even with the pins now showing another value
		strap = 5'h0a;
		mgr_u.wr(5'h10, 16'h8025);
		`CHK(owe, 1'b1)
		@(posedge clock) #1 soft_reset = 1'b1;
		@(posedge clock) #1 soft_reset = 1'b0;
		rchk(16'h0548);
		`CHK(phy_address, 5'h15)
		$display("test soft reset done");
		// Coder: standard table unless test bit and error both set
		for (int i = 0; i < 16; i++) nib(i[3:0], 1'b1, STD[i]);
		mgr_u.wr(5'h10, 16'h0004);
		for (int i = 0; i < 16; i++) nib(i[3:0], 1'b0, STD[i]);
		for (int i = 0; i < 16; i++) nib(i[3:0], 1'b1, TST[i]);
		$display("test coder done");
		// Line encoding: NRZ passes the bit, NRZI toggles on one
		mgr_u.wr(5'h10, 16'h0000);
		sbit(1'b1, 1'b1);
		sbit(1'b0, 1'b0);
		line_exp = 1'b0;
		mgr_u.wr(5'h10, 16'h0008);
		for (int i = 0; i < 6; i++) begin
			line_exp = line_exp ^ i[0];
			sbit(i[0], line_exp);
		end
		$display("test line encoding done");
		// A second hardware reset reloads the address from the new strap value;
		// reset is lowered just after an edge so it never races the sampling edge
		repeat (2) @(posedge clock);
		#1 hw_reset();
		rchk(16'h0288);
		`CHK(phy_address, 5'h0a)
		$display("test address reload done");
		stop_test();
	end
endmodule // test_phy_extended_control_register

`default_nettype wire
